// file: pkg/acc_pkg.sv
// Overview of operation
// - Mux enable set and converter off routes input pin chosen by select bits.
// - Reference and channel selections reach converter only once enabled.
// - Ten-bit result split high and low, right aligned unless alignment set.
// - Reading low result blocks result updates until high result is read.
// - Completion while blocked leaves results unchanged, new result discarded.
// - Reading high result re-enables updates of both result registers.
// - Completion flag still sets when a result is discarded.
// - Start bit begins one conversion, stays set, hardware clears at end.
// - Channel change mid conversion applies only after the current one.
// - Auto-trigger enable starts conversions from the selected trigger source.
// - Trigger rising edge resets the prescaler and starts a conversion.
// - Trigger still high at completion starts nothing; only fresh edges.
// - Trigger edges during a conversion are ignored.
// - Trigger flags set even if masked; software clears before next event.
// - Own completion flag as trigger restarts at every end regardless.
// - With auto-trigger on, start bit still starts a conversion, single unless own completion flag is the trigger.
// - Start bit reads one during any conversion however started.
// - Normal conversion 13 converter clocks, first after enable 25.
// - At completion write results, set flag, clear start bit if single.
// - Prescaler counts only while enabled, held in reset otherwise.
package acc_pkg;
	localparam logic [11:0] ACC_CTRL_OFF   = 12'h000; // Control and status
	localparam logic [11:0] ACC_SEL_OFF    = 12'h004; // Channel/reference
	localparam logic [11:0] ACC_RESL_OFF   = 12'h008; // Result low
	localparam logic [11:0] ACC_RESH_OFF   = 12'h00C; // Result high
	localparam logic [11:0] ACC_SFR_OFF    = 12'h010; // Special function
	// Control bit positions
	localparam int ACC_EN_BIT    = 7;
	localparam int ACC_START_BIT = 6;
	localparam int ACC_AUTO_BIT  = 5;
	localparam int ACC_FLAG_BIT  = 4;
	// Select register positions
	localparam int ACC_ALIGN_BIT = 5;
	// Special function positions
	localparam int ACC_CMUX_BIT  = 3;
	localparam int ACC_TSEL_LSB  = 5;
	localparam logic [7:0] ACC_RESET_VAL = 8'h00;
	localparam logic [4:0] ACC_NORMAL_CYC = 5'd13;
	localparam logic [4:0] ACC_FIRST_CYC  = 5'd25;
	localparam logic [2:0] ACC_TSEL_SELF  = 3'h0;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WAIT = 2'b01,
		ACC_CONV = 2'b10
	} acc_state_t;
endpackage

// file: verilog/acc_conversion_control.sv
`timescale 1ns/1ps
module acc_conversion_control
	import acc_pkg::*;
#(
	parameter int PRESC_DIV = 2
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  triggerSources,
	input  wire logic [9:0]  sampleValue,
	output logic      [2:0]  activeChannel,
	output logic      [1:0]  activeReference,
	output logic             sampleHold,
	output logic             comparatorMuxActive,
	output logic      [2:0]  comparatorChannel
);
	logic [7:0] ctrl, sel, sfr;
	logic [7:0] resultHigh, resultLow;
	logic       resultBlocked, firstPending;
	logic [7:0] prescCnt;
	logic       adcTick;
	logic [4:0] cycCnt;
	acc_state_t state;
	logic [2:0] trigSync;
	logic       trigPrev;
	logic       setupPhase, wrAcc, rdAcc;
	logic       swStart, trigEdge, done, startNow;
	logic [7:0] rdMux;

	// Aligned word fields of the result
	function automatic logic [15:0] align_res(logic [9:0] v, logic left);
		align_res = left ? {v, 6'h00} : {6'h00, v};
	endfunction

	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	assign setupPhase = psel && !penable;
	assign swStart = wrAcc && paddr == ACC_CTRL_OFF && pwdata[ACC_START_BIT];
	assign done = state == ACC_CONV && adcTick && cycCnt == 5'd1;
	// Edge from third stage; previous level updates only when second and third stages agree
	assign trigEdge = trigSync[2] && !trigPrev;
	assign startNow = ctrl[ACC_EN_BIT] && state == ACC_IDLE
		&& (swStart
		|| (ctrl[ACC_AUTO_BIT] && trigEdge));

	// Software registers; start bit also tracks busy
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= ACC_RESET_VAL;
			sel  <= ACC_RESET_VAL;
			sfr  <= ACC_RESET_VAL;
		end else begin
			if (wrAcc && paddr == ACC_CTRL_OFF) begin
				ctrl[ACC_EN_BIT]   <= pwdata[ACC_EN_BIT];
				ctrl[ACC_AUTO_BIT] <= pwdata[ACC_AUTO_BIT];
				ctrl[3:0]          <= pwdata[3:0];
			end
			if (wrAcc && paddr == ACC_SEL_OFF)
				sel <= pwdata[7:0];
			if (wrAcc && paddr == ACC_SFR_OFF)
				sfr <= {pwdata[7:5], 1'b0, pwdata[3:0]};
			// Start bit high from request to end of conversion
			if (startNow || (swStart && ctrl[ACC_EN_BIT]))
				ctrl[ACC_START_BIT] <= 1'b1;
			else if (done && !(ctrl[ACC_AUTO_BIT]
				&& sfr[ACC_TSEL_LSB +: 3] == ACC_TSEL_SELF))
				ctrl[ACC_START_BIT] <= 1'b0;
			else if (!ctrl[ACC_EN_BIT])
				ctrl[ACC_START_BIT] <= 1'b0;
			// Set wins over write-one-to-clear
			if (done)
				ctrl[ACC_FLAG_BIT] <= 1'b1;
			else if (wrAcc && paddr == ACC_CTRL_OFF && pwdata[ACC_FLAG_BIT])
				ctrl[ACC_FLAG_BIT] <= 1'b0;
		end
	end

	// Prescaler held in reset while disabled or on trigger
	always_ff @(posedge sys_clk) begin
		if (!nrst || !ctrl[ACC_EN_BIT]) begin
			prescCnt <= 8'h00;
			adcTick  <= 1'b0;
		end else if (startNow && !swStart) begin
			prescCnt <= 8'h00;
			adcTick  <= 1'b0;
		end else if (prescCnt == 8'(PRESC_DIV - 1)) begin
			prescCnt <= 8'h00;
			adcTick  <= 1'b1;
		end else begin
			prescCnt <= prescCnt + 8'h01;
			adcTick  <= 1'b0;
		end
	end

	// Trigger synchroniser, three stages
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			trigSync <= 3'b000;
			trigPrev <= 1'b0;
		end else begin
			trigSync <= {trigSync[1:0],
				triggerSources[sfr[ACC_TSEL_LSB +: 3]]};
			if (trigSync[2] == trigSync[1])
				trigPrev <= trigSync[2];
		end
	end

	// Conversion sequencer
	always_ff @(posedge sys_clk) begin
		if (!nrst || !ctrl[ACC_EN_BIT]) begin
			state        <= ACC_IDLE;
			cycCnt       <= 5'd0;
			firstPending <= 1'b1;
			activeChannel   <= 3'h0;
			activeReference <= 2'h0;
			sampleHold      <= 1'b0;
		end else begin
			case (state)
				ACC_IDLE: begin
					// Selections track until start locks them
					activeChannel   <= sel[2:0];
					activeReference <= sel[7:6];
					if (startNow)
						state <= ACC_WAIT;
				end
				ACC_WAIT: if (adcTick) begin
					state  <= ACC_CONV;
					cycCnt <= firstPending ? ACC_FIRST_CYC
						: ACC_NORMAL_CYC;
					firstPending <= 1'b0;
					sampleHold   <= 1'b1;
				end
				ACC_CONV: if (adcTick) begin
					cycCnt <= cycCnt - 5'd1;
					if (cycCnt == 5'd1) begin
						sampleHold <= 1'b0;
						// Self trigger restarts at once
						if (ctrl[ACC_AUTO_BIT] && sfr[ACC_TSEL_LSB +: 3]
							== ACC_TSEL_SELF) begin
							state  <= ACC_CONV;
							cycCnt <= ACC_NORMAL_CYC;
							activeChannel <= sel[2:0];
						end else
							state <= ACC_IDLE;
					end else
						sampleHold <= 1'b1; // Back high once a restart runs
				end
				default: state <= ACC_IDLE;
			endcase
		end
	end

	// Result registers with read-order lock
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			resultHigh    <= 8'h00;
			resultLow     <= 8'h00;
			resultBlocked <= 1'b0;
		end else begin
			if (done && !resultBlocked) begin
				{resultHigh, resultLow} <=
					align_res(sampleValue, sel[ACC_ALIGN_BIT]);
			end
			if (rdAcc && paddr == ACC_RESL_OFF)
				resultBlocked <= 1'b1;
			else if (rdAcc && paddr == ACC_RESH_OFF)
				resultBlocked <= 1'b0;
		end
	end

	// Comparator negative input selection
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			comparatorMuxActive <= 1'b0;
			comparatorChannel   <= 3'h0;
		end else begin
			comparatorMuxActive <= sfr[ACC_CMUX_BIT]
				&& !ctrl[ACC_EN_BIT];
			comparatorChannel   <= sel[2:0];
		end
	end

	always_comb begin
		rdMux = 8'h00;
		case (paddr)
			ACC_CTRL_OFF: rdMux = ctrl;
			ACC_SEL_OFF:  rdMux = sel;
			ACC_RESL_OFF: rdMux = resultLow;
			ACC_RESH_OFF: rdMux = resultHigh;
			ACC_SFR_OFF:  rdMux = sfr;
			default:      rdMux = 8'h00;
		endcase
	end

	// APB answer: no wait states, data registered in setup
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setupPhase;
			prdata  <= setupPhase ? {24'h00_0000, rdMux} : 32'h0000_0000;
			pslverr <= setupPhase && paddr != ACC_CTRL_OFF
				&& paddr != ACC_SEL_OFF && paddr != ACC_RESL_OFF
				&& paddr != ACC_RESH_OFF && paddr != ACC_SFR_OFF;
		end
	end

	chk_start_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == ACC_CONV |-> ctrl[ACC_START_BIT])
		else $error("start bit low during conversion");
	chk_flag_on_done: assert property (@(posedge sys_clk) disable iff (!nrst)
		done |=> ctrl[ACC_FLAG_BIT])
		else $error("flag not set at completion");
	chk_block_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		resultBlocked && done |=> $stable(resultLow))
		else $error("blocked result changed");
	chk_unblock_high: assert property (@(posedge sys_clk) disable iff (!nrst)
		rdAcc && paddr == ACC_RESH_OFF |=> !resultBlocked)
		else $error("high read did not unblock");
	chk_cmux_route: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl[ACC_EN_BIT] |=> !comparatorMuxActive)
		else $error("comparator mux active while enabled");
	chk_presc_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl[ACC_EN_BIT] |=> prescCnt == 8'h00)
		else $error("prescaler ran while disabled");
	chk_no_retrig: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == ACC_CONV && !done |=> state != ACC_WAIT)
		else $error("trigger restarted mid conversion");
	chk_conv_len: assert property (@(posedge sys_clk) disable iff (!nrst)
		state == ACC_WAIT && adcTick && !firstPending
		|=> cycCnt == ACC_NORMAL_CYC)
		else $error("normal conversion length wrong");
	cov_single: cover property (@(posedge sys_clk) swStart ##[1:200] done);
	cov_lost: cover property (@(posedge sys_clk) resultBlocked && done);
	cov_trig: cover property (@(posedge sys_clk) trigEdge && startNow);
endmodule // acc_conversion_control

// file: verif/acc_conversion_control_tb.sv
`timescale 1ns/1ps
module acc_conversion_control_tb
	import acc_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        sampleHold;
	logic        comparatorMuxActive;
	logic [7:0]  triggerSources = 8'h00;
	logic [9:0]  sampleValue = 10'h000;
	logic [2:0]  activeChannel;
	logic [2:0]  comparatorChannel;
	logic [1:0]  activeReference;
	int          errTotal = 0;
	int          compares = 0;
	int          n;

	acc_conversion_control #(.PRESC_DIV(2)) acc_conversion_control_i (
		.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.triggerSources(triggerSources), .sampleValue(sampleValue),
		.activeChannel(activeChannel), .activeReference(activeReference),
		.sampleHold(sampleHold), .comparatorMuxActive(comparatorMuxActive),
		.comparatorChannel(comparatorChannel));

	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;

	// Single exit point of the run
	task give_verdict;
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Case equality, so an unknown never passes
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			chk(0, 1, "apb hang");
			give_verdict();
		end
	endtask

	task rc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask

	// Bounded wait on sampleHold; a miss ends the run
	task hold(input logic lv, input int lim);
		n = 0;
		while (sampleHold !== lv && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= lim) begin
			chk(0, 1, "hold wait");
			give_verdict();
		end
	endtask

	// Count cycles with sampleHold high over 40 cycles
	task quiet;
		n = 0;
		repeat (40) begin
			@(posedge sys_clk);
			n += int'(sampleHold);
		end
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		rc(ACC_CTRL_OFF, 32'h0, "ctrl reset");
		apb(1'b0, 12'h014, 32'h0);
		chk(32'(er), 32'h1, "unmapped");
		$display("test reset done");
		apb(1'b1, ACC_SFR_OFF, 32'h08);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, ACC_SEL_OFF, 32'(c));
			repeat (2) @(posedge sys_clk);
			chk(32'(comparatorMuxActive), 32'h1, "mux on");
			chk(32'(comparatorChannel), 32'(c), "mux ch");
		end
		apb(1'b1, ACC_SEL_OFF, 32'h83);
		repeat (2) @(posedge sys_clk);
		chk(32'(activeChannel), 32'h0, "held sel");
		sampleValue <= 10'h2A5;
		apb(1'b1, ACC_CTRL_OFF, 32'h80);
		apb(1'b1, ACC_CTRL_OFF, 32'hC0);
		chk(32'(comparatorMuxActive), 32'h0, "mux off");
		chk(32'({activeReference, activeChannel}), 32'h13, "sel");
		// First conversion is the long one
		hold(1'b1, 20);
		hold(1'b0, 80);
		chk(32'(n >= 46 && n <= 52), 32'h1, "first len");
		rc(ACC_CTRL_OFF, 32'h90, "done");
		rc(ACC_RESL_OFF, 32'hA5, "low");
		rc(ACC_RESH_OFF, 32'h02, "high");
		sampleValue <= 10'h155;
		apb(1'b1, ACC_CTRL_OFF, 32'hD0);
		hold(1'b1, 20);
		hold(1'b0, 80);
		chk(32'(n >= 22 && n <= 28), 32'h1, "normal len");
		rc(ACC_RESL_OFF, 32'h55, "low2");
		$display("test single done");
		// Conversion while low result is held: must be discarded
		sampleValue <= 10'h2A5;
		apb(1'b1, ACC_CTRL_OFF, 32'hD0);
		rc(ACC_CTRL_OFF, 32'hC0, "busy");
		apb(1'b1, ACC_SEL_OFF, 32'h86);
		chk(32'(activeChannel), 32'h3, "old ch");
		hold(1'b0, 80);
		repeat (3) @(posedge sys_clk);
		chk(32'(activeChannel), 32'h6, "new ch");
		rc(ACC_CTRL_OFF, 32'h90, "flag");
		rc(ACC_RESH_OFF, 32'h01, "kept hi");
		rc(ACC_RESL_OFF, 32'h55, "kept lo");
		rc(ACC_RESH_OFF, 32'h01, "unlock");
		apb(1'b1, ACC_SEL_OFF, 32'hA6);
		sampleValue <= 10'h155;
		apb(1'b1, ACC_CTRL_OFF, 32'hD0);
		hold(1'b1, 20);
		hold(1'b0, 80);
		rc(ACC_RESL_OFF, 32'h40, "left lo");
		rc(ACC_RESH_OFF, 32'h55, "left hi");
		$display("test lock done");
		// Trigger input 1: one start per fresh edge only
		apb(1'b1, ACC_SFR_OFF, 32'h20);
		apb(1'b1, ACC_CTRL_OFF, 32'hB0);
		triggerSources <= 8'h02;
		hold(1'b1, 30);
		rc(ACC_CTRL_OFF, 32'hE0, "trig busy");
		triggerSources <= 8'h00;
		repeat (3) @(posedge sys_clk);
		triggerSources <= 8'h02;
		hold(1'b0, 60);
		quiet();
		chk(n, 0, "no restart");
		apb(1'b1, ACC_CTRL_OFF, 32'hF0);
		hold(1'b1, 20);
		hold(1'b0, 60);
		quiet();
		chk(n, 0, "single");
		$display("test trigger done");
		// Own completion as trigger keeps converting, flag never cleared
		triggerSources <= 8'h00;
		apb(1'b1, ACC_SFR_OFF, 32'h00);
		apb(1'b1, ACC_CTRL_OFF, 32'hF0);
		hold(1'b1, 20);
		hold(1'b0, 60);
		hold(1'b1, 20);
		hold(1'b0, 60);
		hold(1'b1, 20);
		rc(ACC_CTRL_OFF, 32'hF0, "free run");
		$display("test free run done");
		give_verdict();
	end
endmodule // acc_conversion_control_tb
